// ### include/gate_prot_cfg.svh
// Purpose: Timing constants for the gate protection logic
// Assumes: 25 MHz clock, 40 ns period
// Notes:   Times kept in ns; cycle counts derived from them
`ifndef GATE_PROT_CFG_SVH
`define GATE_PROT_CFG_SVH
`define CLK_PERIOD_NS      40
`define UV_FILTER_NS       3000
`define BLANKING_NS        500
`define OC_HOLD_NS         30000
`define SIMUL_FILTER_NS    800
`define UV_FILTER_CYC      (`UV_FILTER_NS / `CLK_PERIOD_NS)
`define BLANKING_CYC       ((`BLANKING_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define OC_HOLD_CYC        (`OC_HOLD_NS / `CLK_PERIOD_NS)
`define SIMUL_FILTER_CYC   (`SIMUL_FILTER_NS / `CLK_PERIOD_NS)
`define CNT_W              10
`define PHASES             3
`endif

// ### include/gate_prot_pkg.sv
// Purpose: Types for the gate protection logic
// Assumes: Three phases
// Notes:   Count widths fit the longest hold
package gate_prot_pkg;
  typedef logic [2:0] phase_vec_t;
  typedef logic [9:0] cnt_t;
  typedef struct packed {
    phase_vec_t high_side_cmd;
    phase_vec_t low_side_cmd;
  } cmd_t;
  typedef struct packed {
    phase_vec_t high_gate_drive;
    phase_vec_t low_gate_drive;
  } gate_t;
  typedef struct packed {
    phase_vec_t bootstrap_uv;
    logic       logic_uv;
    logic       overcurrent_sense;
    cmd_t       cmd;
  } sync_t;
  typedef struct packed {
    sync_t      s1;
    sync_t      s2;
    phase_vec_t hs_cmd_d;
    cnt_t [2:0] hs_uv_cnt;
    phase_vec_t high_supply_lockout;
    phase_vec_t hs_rearm;
    cnt_t       vcc_uv_cnt;
    logic       logic_supply_lockout;
    cnt_t       blank_cnt;
    cnt_t       hold_cnt;
    logic       oc_active;
    cnt_t [2:0] simul_cnt;
    phase_vec_t simul_active;
    gate_t      gate;
    logic       fault_out_n;
  } state_t;
endpackage

// ### hw/gate_prot.sv
// Purpose: Protection and gating for one three-phase gate driver
// Assumes: Undervoltage and overcurrent arrive as comparator levels
// Notes:   All inputs except clk and arst_n pass two flip-flops before use
`timescale 1ns/1ps
`include "gate_prot_cfg.svh"
module gate_prot (
  input  wire logic                    clk,
  input  wire logic                    arst_n,
  input  wire gate_prot_pkg::cmd_t     cmd,
  input  wire gate_prot_pkg::phase_vec_t bootstrap_supply_low,
  input  wire logic                    logic_supply_low,
  input  wire logic                    overcurrent_sense,
  output gate_prot_pkg::gate_t         gate,
  output logic                         fault_out_n
);
  import gate_prot_pkg::*;

  state_t st_r;
  state_t st_nxt;

  localparam cnt_t UV_LIM    = cnt_t'(`UV_FILTER_CYC);
  localparam cnt_t BLANK_LIM = cnt_t'(`BLANKING_CYC);
  localparam cnt_t HOLD_LIM  = cnt_t'(`OC_HOLD_CYC);
  localparam cnt_t SIM_LIM   = cnt_t'(`SIMUL_FILTER_CYC);

  // Saturating filter count: up while condition holds, cleared otherwise
  function automatic cnt_t filt(input logic cond, input cnt_t c, input cnt_t lim);
    if (!cond)
      filt = '0;
    else if (c < lim)
      filt = c + cnt_t'(1);
    else
      filt = c;
  endfunction

  logic fault_any;
  logic hs_edge;

  always_comb begin
    st_nxt = st_r;
    fault_any = 1'b0;
    hs_edge = 1'b0;
    st_nxt.s1.bootstrap_uv      = bootstrap_supply_low;
    st_nxt.s1.logic_uv          = logic_supply_low;
    st_nxt.s1.overcurrent_sense = overcurrent_sense;
    st_nxt.s1.cmd               = cmd;
    st_nxt.s2 = st_r.s1;
    st_nxt.hs_cmd_d = st_r.s2.cmd.high_side_cmd;
    // Logic supply lockout with glitch filter
    st_nxt.vcc_uv_cnt = filt(st_r.s2.logic_uv, st_r.vcc_uv_cnt, UV_LIM);
    st_nxt.logic_supply_lockout = st_r.s2.logic_uv ? (st_nxt.vcc_uv_cnt == UV_LIM) : 1'b0;
    // Overcurrent blanking and hold
    st_nxt.blank_cnt = filt(st_r.s2.overcurrent_sense, st_r.blank_cnt, BLANK_LIM);
    if (st_nxt.blank_cnt == BLANK_LIM) begin
      st_nxt.oc_active = 1'b1;
      st_nxt.hold_cnt  = '0;
    end else if (st_r.oc_active) begin
      if (st_r.hold_cnt == HOLD_LIM - cnt_t'(1))
        st_nxt.oc_active = 1'b0;
      else
        st_nxt.hold_cnt = st_r.hold_cnt + cnt_t'(1);
    end
    for (int p = 0; p < `PHASES; p++) begin
      st_nxt.hs_uv_cnt[p] = filt(st_r.s2.bootstrap_uv[p], st_r.hs_uv_cnt[p], UV_LIM);
      if (st_nxt.hs_uv_cnt[p] == UV_LIM) begin
        st_nxt.high_supply_lockout[p] = 1'b1;
        st_nxt.hs_rearm[p] = 1'b1;
      end else if (!st_r.s2.bootstrap_uv[p]) begin
        st_nxt.high_supply_lockout[p] = 1'b0;
      end
      hs_edge = st_r.s2.cmd.high_side_cmd[p] & ~st_r.hs_cmd_d[p];
      if (!st_nxt.high_supply_lockout[p] && hs_edge)
        st_nxt.hs_rearm[p] = 1'b0;
      st_nxt.simul_cnt[p] = filt(st_r.s2.cmd.high_side_cmd[p] & st_r.s2.cmd.low_side_cmd[p],
                                 st_r.simul_cnt[p], SIM_LIM);
      st_nxt.simul_active[p] = (st_nxt.simul_cnt[p] == SIM_LIM);
    end
    // High-side lockout is deliberately left out of the fault term
    fault_any = st_nxt.logic_supply_lockout | st_nxt.oc_active | (|st_nxt.simul_active);
    st_nxt.fault_out_n = ~fault_any;
    for (int p = 0; p < `PHASES; p++) begin
      st_nxt.gate.high_gate_drive[p] = st_r.s2.cmd.high_side_cmd[p] & ~fault_any
                                       & ~st_nxt.high_supply_lockout[p] & ~st_nxt.hs_rearm[p];
      st_nxt.gate.low_gate_drive[p]  = st_r.s2.cmd.low_side_cmd[p] & ~fault_any;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_r <= '0;
      st_r.fault_out_n <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign gate = st_r.gate;
  assign fault_out_n = st_r.fault_out_n;

  property p_fault_gates_off;
    @(posedge clk) disable iff (!arst_n)
    !fault_out_n |-> (gate.high_gate_drive == 3'h0 && gate.low_gate_drive == 3'h0);
  endproperty
  a_fault_gates_off: assert property (p_fault_gates_off) else $error("gate on during fault");

  property p_hs_lock_no_fault;
    @(posedge clk) disable iff (!arst_n)
    (st_r.high_supply_lockout != 3'h0 && !st_r.logic_supply_lockout && !st_r.oc_active
     && st_r.simul_active == 3'h0) |-> fault_out_n;
  endproperty
  a_hs_lock_no_fault: assert property (p_hs_lock_no_fault) else $error("fault from high-side lockout");

  property p_hs_lock_gate;
    @(posedge clk) disable iff (!arst_n)
    st_r.high_supply_lockout[0] |-> !gate.high_gate_drive[0];
  endproperty
  a_hs_lock_gate: assert property (p_hs_lock_gate) else $error("high gate on in lockout");

  property p_vcc_fault;
    @(posedge clk) disable iff (!arst_n)
    st_r.logic_supply_lockout |-> !fault_out_n && gate.low_gate_drive == 3'h0;
  endproperty
  a_vcc_fault: assert property (p_vcc_fault) else $error("logic lockout without fault");

  property p_uv_short_ignored;
    @(posedge clk) disable iff (!arst_n)
    $rose(st_r.s2.logic_uv) |=> !st_r.logic_supply_lockout [*8];
  endproperty
  a_uv_short_ignored: assert property (p_uv_short_ignored) else $error("logic lockout too early");

  property p_oc_blank;
    @(posedge clk) disable iff (!arst_n)
    $rose(st_r.oc_active) |-> $past(st_r.s2.overcurrent_sense, 13);
  endproperty
  a_oc_blank: assert property (p_oc_blank) else $error("overcurrent trip before blanking");

  property p_oc_hold;
    @(posedge clk) disable iff (!arst_n)
    $rose(st_r.oc_active) |-> st_r.oc_active [*8] ##1 (st_r.oc_active || st_r.hold_cnt > 10'h0008);
  endproperty
  a_oc_hold: assert property (p_oc_hold) else $error("overcurrent hold too short");

  property p_oc_release;
    @(posedge clk) disable iff (!arst_n)
    (!st_r.s2.overcurrent_sense && $rose(st_r.oc_active)) |-> ##[1:760] !st_r.oc_active;
  endproperty
  a_oc_release: assert property (p_oc_release) else $error("overcurrent hold never ends");

  property p_simul_fault;
    @(posedge clk) disable iff (!arst_n)
    (st_r.simul_active != 3'h0) |-> !fault_out_n;
  endproperty
  a_simul_fault: assert property (p_simul_fault) else $error("overlap without fault");

  property p_simul_filter;
    @(posedge clk) disable iff (!arst_n)
    $rose(st_r.simul_active[0]) |-> $past(st_r.s2.cmd.high_side_cmd[0] & st_r.s2.cmd.low_side_cmd[0], 19);
  endproperty
  a_simul_filter: assert property (p_simul_filter) else $error("overlap filter too short");

  property p_pass;
    @(posedge clk) disable iff (!arst_n)
    (st_nxt.fault_out_n && !st_nxt.hs_rearm[1] && !st_nxt.high_supply_lockout[1])
      |=> gate.low_gate_drive[1] == $past(st_r.s2.cmd.low_side_cmd[1])
          && gate.high_gate_drive[1] == $past(st_r.s2.cmd.high_side_cmd[1]);
  endproperty
  a_pass: assert property (p_pass) else $error("commands not passed");

  property p_hs_lock_all;
    @(posedge clk) disable iff (!arst_n)
    (st_r.high_supply_lockout & gate.high_gate_drive) == 3'h0;
  endproperty
  a_hs_lock_all: assert property (p_hs_lock_all) else $error("high gate on in a locked phase");

  property p_rearm_hold;
    @(posedge clk) disable iff (!arst_n)
    (st_r.hs_rearm & gate.high_gate_drive) == 3'h0;
  endproperty
  a_rearm_hold: assert property (p_rearm_hold) else $error("high gate on before command edge");

  property p_hs_filter;
    @(posedge clk) disable iff (!arst_n)
    $rose(st_r.high_supply_lockout[0]) |-> $past(st_r.s2.bootstrap_uv[0], `UV_FILTER_CYC);
  endproperty
  a_hs_filter: assert property (p_hs_filter) else $error("bootstrap lockout before filter time");

  property p_vcc_filter;
    @(posedge clk) disable iff (!arst_n)
    $rose(st_r.logic_supply_lockout) |-> $past(st_r.s2.logic_uv, `UV_FILTER_CYC);
  endproperty
  a_vcc_filter: assert property (p_vcc_filter) else $error("logic lockout before filter time");

  property p_oc_gates;
    @(posedge clk) disable iff (!arst_n)
    st_r.oc_active |-> !fault_out_n && gate.high_gate_drive == 3'h0 && gate.low_gate_drive == 3'h0;
  endproperty
  a_oc_gates: assert property (p_oc_gates) else $error("gate on during overcurrent");

  property p_low_follow;
    @(posedge clk) disable iff (!arst_n)
    fault_out_n |-> gate.low_gate_drive == $past(st_r.s2.cmd.low_side_cmd);
  endproperty
  a_low_follow: assert property (p_low_follow) else $error("low gate not following command");
endmodule // gate_prot

// ### sim/ctrl_model.sv
// Purpose: Controller model issuing gate commands
// Assumes: Dead time already present in want
// Notes:   Stops on fault when obey is set
`timescale 1ns/1ps
module ctrl_model
  import gate_prot_pkg::*;
#(parameter int WAIT_CYC = 100) (
  input  wire logic                  clk,
  input  wire logic                  obey,
  input  wire gate_prot_pkg::cmd_t   want,
  input  wire logic                  fault_out_n,
  output gate_prot_pkg::cmd_t        cmd
);
  int quiet = WAIT_CYC;
  always @(negedge clk) begin
    if (obey && !fault_out_n) quiet <= 0;
    else if (quiet < WAIT_CYC) quiet <= quiet + 1;
  end
  assign cmd = (quiet < WAIT_CYC) ? '0 : want;
endmodule // ctrl_model

// ### sim/tb_gate_drive_protection_logic.sv
// Purpose: Self-checking bench for the gate protection logic
// Assumes: UV filter 75, blanking 13, hold 750, overlap 20 cycles
// Notes:   Outputs follow inputs three edges later
`timescale 1ns/1ps
module tb_gate_drive_protection_logic;
  import gate_prot_pkg::*;
  logic       clk;
  logic       arst_n;
  logic       obey;
  cmd_t       want;
  cmd_t       cmd;
  phase_vec_t bs_low;
  logic       vcc_low;
  logic       oc;
  gate_t      gate;
  logic       fault_out_n;
  int         fail_count;
  int         checked;

  gate_prot DUT (.clk(clk), .arst_n(arst_n), .cmd(cmd), .bootstrap_supply_low(bs_low),
    .logic_supply_low(vcc_low), .overcurrent_sense(oc), .gate(gate), .fault_out_n(fault_out_n));
  ctrl_model #(.WAIT_CYC(100)) partner (.clk(clk), .obey(obey), .want(want),
    .fault_out_n(fault_out_n), .cmd(cmd));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic chk(input logic f, input phase_vec_t h, input phase_vec_t l);
    checked++;
    if ({fault_out_n, gate} !== {f, h, l}) begin
      fail_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, {fault_out_n, gate}, {f, h, l});
    end
  endtask

  task automatic drive(input phase_vec_t h, input phase_vec_t l, input int n);
    want = '{high_side_cmd: h, low_side_cmd: l};
    cyc(n);
  endtask

  task automatic conclude();
    $display("checked=%0d fail_count=%0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic boot_uv();
    drive(3'h7, 3'h0, 5);
    bs_low = 3'h1;
    cyc(30);
    chk(1'b1, 3'h7, 3'h0);
    cyc(60);
    chk(1'b1, 3'h6, 3'h0);
    bs_low = 3'h0;
    cyc(6);
    chk(1'b1, 3'h6, 3'h0);
    drive(3'h6, 3'h0, 5);
    drive(3'h7, 3'h0, 5);
    chk(1'b1, 3'h7, 3'h0);
  endtask

  task automatic logic_uv();
    drive(3'h5, 3'h2, 5);
    vcc_low = 1'b1;
    cyc(30);
    chk(1'b1, 3'h5, 3'h2);
    cyc(60);
    chk(1'b0, 3'h0, 3'h0);
    vcc_low = 1'b0;
    cyc(6);
    chk(1'b1, 3'h5, 3'h2);
  endtask

  task automatic over_cur();
    obey = 1'b1;
    oc   = 1'b1;
    cyc(12);
    oc = 1'b0;
    cyc(5);
    chk(1'b1, 3'h5, 3'h2);
    oc = 1'b1;
    cyc(13);
    oc = 1'b0;
    cyc(5);
    chk(1'b0, 3'h0, 3'h0);
    cyc(700);
    chk(1'b0, 3'h0, 3'h0);
    cyc(100);
    chk(1'b1, 3'h0, 3'h0);
    cyc(100);
    chk(1'b1, 3'h5, 3'h2);
    obey = 1'b0;
  endtask

  task automatic simul_on();
    drive(3'h1, 3'h0, 5);
    drive(3'h1, 3'h1, 10);
    chk(1'b1, 3'h1, 3'h1);
    drive(3'h1, 3'h0, 5);
    drive(3'h1, 3'h1, 40);
    chk(1'b0, 3'h0, 3'h0);
    drive(3'h0, 3'h1, 6);
    chk(1'b1, 3'h0, 3'h1);
  endtask

  initial begin
    arst_n     = 1'b0;
    obey       = 1'b0;
    want       = '0;
    bs_low     = 3'h0;
    vcc_low    = 1'b0;
    oc         = 1'b0;
    fail_count = 0;
    checked    = 0;
    cyc(10);
    chk(1'b1, 3'h0, 3'h0);
    arst_n = 1'b1;
    drive(3'h5, 3'h2, 5);
    chk(1'b1, 3'h5, 3'h2);
    boot_uv();
    logic_uv();
    over_cur();
    simul_on();
    conclude();
  end
endmodule // tb_gate_drive_protection_logic
